// [verilog/asr_regs.sv]
// Status register bank of a damper actuator, holding-register view
// Assumes one access a cycle from a decoded serial-bus front end
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.svh"

module asr_regs #(
  parameter longint unsigned WD_CYCLES = `ASR_WD_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register access
  input wire asr_pkg::asr_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Actuator state
  input wire logic [1:0] category,
  input wire logic [15:0] abs_position,
  input wire asr_pkg::asr_flow_s flow,
  input wire logic [15:0] sensor_scaled,
  input wire logic [15:0] serial_part1,
  input wire logic [15:0] serial_part2,
  input wire logic [15:0] serial_part4,
  input wire logic [7:0] fault_events,
  input wire logic activity,
  input wire logic gear_released,
  // Actuator control
  output logic [15:0] setpoint,
  output logic [15:0] override_mode,
  output logic [15:0] command,
  output logic fail_close,
  output logic fail_open
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic is_addr(input logic [15:0] a,
                                   input logic [15:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  function automatic logic is_cat(input logic [1:0] c,
                                  input logic [15:0] code);
    is_cat = ({14'h0000, c} == code);
  endfunction

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  // Counter is 33 bits so that 120 s at 40 MHz fits
  localparam logic [32:0] WD_LAST = 33'(WD_CYCLES - 64'h1);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] setpoint_ff, nxt_setpoint;
  logic [15:0] override_ff, nxt_override;
  logic [15:0] command_ff, nxt_command;
  logic [15:0] fail_pos_ff, nxt_fail_pos;
  logic [7:0] fault_ff, nxt_fault;
  logic [32:0] wd_cnt_ff, nxt_wd_cnt;
  asr_pkg::asr_wd_e wd_ff, nxt_wd;
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic fclose_ff, nxt_fclose;
  logic fopen_ff, nxt_fopen;
  logic wr_sp, wr_ov, wr_cmd, wr_fp;
  logic [7:0] fault_mask;
  logic [15:0] status_word;
  logic cat_flow;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // Only these four addresses take a write
  assign wr_sp = req.wr && is_addr(req.addr, `ASR_ADDR_SETPOINT);
  assign wr_ov = req.wr && is_addr(req.addr, `ASR_ADDR_OVERRIDE);
  assign wr_cmd = req.wr && is_addr(req.addr, `ASR_ADDR_COMMAND);
  assign wr_fp = req.wr && is_addr(req.addr, `ASR_ADDR_FAIL_POS);
  assign cat_flow = is_cat(category, `ASR_CAT_FLOW);
  // Fire faults only for fire dampers, bit 3 never set
  always_comb
  begin
    fault_mask = `ASR_LOW_MASK;
    if (is_cat(category, `ASR_CAT_FIRE))
    begin
      fault_mask = fault_mask | `ASR_FIRE_MASK;
    end
  end

  // ------------------------------------------------------------
  // Writable registers and fault latch
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_setpoint = setpoint_ff;
    nxt_override = override_ff;
    nxt_fail_pos = fail_pos_ff;
    nxt_command = `ASR_CMD_NONE;
    nxt_fault = fault_ff;
    if (wr_sp)
    begin
      nxt_setpoint = req.wdata;
    end
    if (wr_ov)
    begin
      nxt_override = req.wdata;
    end
    if (wr_fp)
    begin
      nxt_fail_pos = req.wdata;
    end
    if (wr_cmd)
    begin
      nxt_command = req.wdata;
    end
    if (wr_cmd && req.wdata == `ASR_CMD_CLR_FAULT)
    begin
      nxt_fault = fault_ff & `ASR_FAULT_KEEP;
    end
    // New events win over the clear
    nxt_fault = (nxt_fault | fault_events) & fault_mask;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      setpoint_ff <= 16'h0000;
      override_ff <= 16'h0000;
      command_ff <= `ASR_CMD_NONE;
      fail_pos_ff <= `ASR_FAIL_HOLD;
      fault_ff <= 8'h00;
    end
    else
    begin
      setpoint_ff <= nxt_setpoint;
      override_ff <= nxt_override;
      command_ff <= nxt_command;
      fail_pos_ff <= nxt_fail_pos;
      fault_ff <= nxt_fault;
    end
  end

  // ------------------------------------------------------------
  // Bus watchdog
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_wd = wd_ff;
    nxt_wd_cnt = wd_cnt_ff;
    nxt_fclose = 1'b0;
    nxt_fopen = 1'b0;
    case (wd_ff)
      asr_pkg::ASR_WD_OFF:
      begin
        nxt_wd_cnt = 33'h0;
        if (nxt_fail_pos != `ASR_FAIL_HOLD)
        begin
          nxt_wd = asr_pkg::ASR_WD_RUN;
        end
      end
      asr_pkg::ASR_WD_RUN:
      begin
        if (wr_sp || wr_ov)
        begin
          nxt_wd_cnt = 33'h0;
        end
        else if (wd_cnt_ff >= WD_LAST)
        begin
          nxt_wd = asr_pkg::ASR_WD_TRIP;
        end
        else
        begin
          nxt_wd_cnt = wd_cnt_ff + 33'h1;
        end
      end
      asr_pkg::ASR_WD_TRIP:
      begin
        if (wr_sp || wr_ov)
        begin
          nxt_wd = asr_pkg::ASR_WD_RUN;
          nxt_wd_cnt = 33'h0;
        end
      end
      default:
      begin
        nxt_wd = asr_pkg::ASR_WD_OFF;
      end
    endcase
    if (nxt_fail_pos == `ASR_FAIL_HOLD)
    begin
      nxt_wd = asr_pkg::ASR_WD_OFF;
    end
    if (nxt_wd == asr_pkg::ASR_WD_TRIP)
    begin
      nxt_fclose = (nxt_fail_pos == `ASR_FAIL_CLOSE);
      nxt_fopen = (nxt_fail_pos == `ASR_FAIL_OPEN);
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wd_ff <= asr_pkg::ASR_WD_OFF;
      wd_cnt_ff <= 33'h0;
      fclose_ff <= 1'b0;
      fopen_ff <= 1'b0;
    end
    else
    begin
      wd_ff <= nxt_wd;
      wd_cnt_ff <= nxt_wd_cnt;
      fclose_ff <= nxt_fclose;
      fopen_ff <= nxt_fopen;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb
  begin
    status_word = 16'h0000;
    status_word[7:0] = fault_ff;
    status_word[`ASR_BIT_ACTIVITY] = activity;
    status_word[`ASR_BIT_GEAR] = gear_released;
    status_word[`ASR_BIT_WATCHDOG] = (wd_ff == asr_pkg::ASR_WD_TRIP);
  end

  always_comb
  begin
    nxt_rvalid = req.rd;
    nxt_rdata = 16'h0000;
    if (req.rd)
    begin
      case (req.addr)
        `ASR_ADDR_SETPOINT: nxt_rdata = setpoint_ff;
        `ASR_ADDR_OVERRIDE: nxt_rdata = override_ff;
        `ASR_ADDR_COMMAND: nxt_rdata = command_ff;
        `ASR_ADDR_CATEGORY: nxt_rdata = {14'h0000, category};
        `ASR_ADDR_ABS_POS: nxt_rdata = abs_position;
        `ASR_ADDR_REL_FLOW:
          nxt_rdata = cat_flow ? flow.rel_flow : `ASR_FLOW_NA;
        `ASR_ADDR_ABS_FLOW:
          nxt_rdata = cat_flow ? flow.abs_flow : `ASR_FLOW_NA;
        `ASR_ADDR_SENSOR: nxt_rdata = sensor_scaled;
        `ASR_ADDR_SERIAL1: nxt_rdata = serial_part1;
        `ASR_ADDR_SERIAL2: nxt_rdata = serial_part2;
        `ASR_ADDR_SERIAL4: nxt_rdata = serial_part4;
        `ASR_ADDR_FIRMWARE: nxt_rdata = `ASR_FW_VERSION;
        `ASR_ADDR_STATUS: nxt_rdata = status_word;
        `ASR_ADDR_FAIL_POS: nxt_rdata = fail_pos_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata = rdata_ff;
  assign rvalid = rvalid_ff;
  assign setpoint = setpoint_ff;
  assign override_mode = override_ff;
  assign command = command_ff;
  assign fail_close = fclose_ff;
  assign fail_open = fopen_ff;

endmodule // asr_regs

`default_nettype wire

// [verilog/asr_defs.svh]
// Register offsets, codes and timing constants of the status register bank
// Included by the package user; holds definitions only
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

`define ASR_ADDR_SETPOINT 16'h0001
`define ASR_ADDR_OVERRIDE 16'h0002
`define ASR_ADDR_COMMAND 16'h0003
`define ASR_ADDR_CATEGORY 16'h0004
`define ASR_ADDR_ABS_POS 16'h0006
`define ASR_ADDR_REL_FLOW 16'h0007
`define ASR_ADDR_ABS_FLOW 16'h0008
`define ASR_ADDR_SENSOR 16'h0009
`define ASR_ADDR_SERIAL1 16'h0065
`define ASR_ADDR_SERIAL2 16'h0066
`define ASR_ADDR_SERIAL4 16'h0067
`define ASR_ADDR_FIRMWARE 16'h0068
`define ASR_ADDR_STATUS 16'h0069
`define ASR_ADDR_FAIL_POS 16'h006D

`define ASR_CAT_NONE 16'h0000
`define ASR_CAT_PLAIN 16'h0001
`define ASR_CAT_FLOW 16'h0002
`define ASR_CAT_FIRE 16'h0003
`define ASR_FLOW_NA 16'hFFFF
`define ASR_FLOW_MAX 16'h2710
`define ASR_CMD_NONE 16'h0000
`define ASR_CMD_CLR_FAULT 16'h0004
`define ASR_FAIL_HOLD 16'h0000
`define ASR_FAIL_CLOSE 16'h0001
`define ASR_FAIL_OPEN 16'h0002

`define ASR_BIT_OVERUSE 0
`define ASR_BIT_SAFETY 4
`define ASR_BIT_ACTIVITY 8
`define ASR_BIT_GEAR 9
`define ASR_BIT_WATCHDOG 10
`define ASR_FAULT_KEEP 8'h11
`define ASR_FIRE_MASK 8'hF0
`define ASR_LOW_MASK 8'h07

`define ASR_CLK_HZ 40000000
`define ASR_WD_SEC 120
`define ASR_WD_CYCLES (64'(`ASR_WD_SEC) * 64'(`ASR_CLK_HZ))
`define ASR_FW_VERSION 16'h0065

`endif

// [verilog/asr_pkg.sv]
// Types of the status register bank
// Used by the bank, the master model, the checker and the bench; no imports
package asr_pkg;

  typedef enum logic [1:0] {
    ASR_WD_OFF,
    ASR_WD_RUN,
    ASR_WD_TRIP
  } asr_wd_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } asr_req_s;

  typedef struct packed {
    logic [15:0] rel_flow;
    logic [15:0] abs_flow;
  } asr_flow_s;

endpackage

// [sim/asr_master.sv]
// Bus master model issuing register requests to the bank
// Driven by task calls from the bench; one access at a time
`timescale 1ns/1ps
`default_nettype none
module asr_master (
  // Clock
  input wire logic clk_sys,
  // Request and answer
  output var asr_pkg::asr_req_s req,
  input wire logic [15:0] rdata
);
  // ------------------------------
  // Requests
  // ------------------------------
  initial req = '0;
  // One write, taken at the next edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    #1 req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // One read, answer one cycle on
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    #1 req = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    #1 req = '{1'b0, 1'b0, ~a, 16'hFFFF};
    d = rdata;
  endtask
endmodule // asr_master
`default_nettype wire

// [sim/asr_regs_sva.sv]
// Checker of the status register bank
// Bound to asr_regs; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module asr_regs_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bus
  input wire asr_pkg::asr_req_s req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  // Actuator side
  input wire logic [1:0] category,
  input wire logic activity,
  input wire logic gear_released,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] command,
  input wire logic fail_close,
  input wire logic fail_open
);
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  chk_cat_read: assert property (req.rd && req.addr == 16'h0004 |=>
    rdata == {14'h0000, $past(category)}) else $error("category wrong");
  chk_flow_na: assert property (req.rd && req.addr == 16'h0007 &&
    category != 2'h2 |=> rdata == 16'hFFFF) else $error("flow not FFFF");
  chk_stat_zero: assert property (req.rd && req.addr == 16'h0069 |=>
    rdata[3] == 1'b0 && rdata[15:11] == 5'h00) else $error("spare bits");
  chk_stat_live: assert property (req.rd && req.addr == 16'h0069 |=>
    rdata[9:8] == {$past(gear_released), $past(activity)})
    else $error("live bits wrong");
  chk_cmd_clear: assert property (command != 16'h0000 |=>
    command == 16'h0000) else $error("command not cleared");
  chk_fail_excl: assert property (!(fail_close && fail_open))
    else $error("both fail outputs");
  chk_wd_restart: assert property (req.wr && req.addr == 16'h0001 |=>
    !fail_close && !fail_open) else $error("trip not cleared");
  chk_ro_hold: assert property (req.wr && req.addr == 16'h0004 |=>
    $stable(setpoint)) else $error("read-only write took effect");
  cover property (fail_close);
  cover property (fail_open);
  cover property (command == 16'h0004);
endmodule // asr_regs_chk
bind asr_regs asr_regs_chk chk (.clk_sys, .rst, .req, .rdata, .rvalid,
  .category, .activity, .gear_released, .setpoint, .command, .fail_close,
  .fail_open);
`default_nettype wire

// [sim/test_asr_regs.sv]
// Self-checking bench of the status register bank
// Uses asr_master as the far-side bus master
`timescale 1ns/1ps
`default_nettype none
module test_asr_regs;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  asr_pkg::asr_req_s req;
  asr_pkg::asr_flow_s flow = '{16'h2710, 16'h0123};
  logic [15:0] rdata, setpoint, override_mode, command, v;
  logic rvalid, fail_close, fail_open;
  logic [1:0] category = 2'h0;
  logic [7:0] fault_events = 8'h00;
  logic activity = 1'b0;
  logic gear_released = 1'b0;
  logic [15:0] abs_position = 16'h0042;
  int fails = 0;
  int compares = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  asr_master m (.clk_sys, .req, .rdata);
  asr_regs #(.WD_CYCLES(100)) uut (.clk_sys, .rst, .req, .rdata, .rvalid,
    .category, .abs_position, .flow, .sensor_scaled(16'h0BB8),
    .serial_part1(16'h0347), .serial_part2(16'h7A02),
    .serial_part4(16'h0008), .fault_events, .activity, .gear_released,
    .setpoint, .override_mode, .command, .fail_close, .fail_open);
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rc(input logic [15:0] a, input logic [15:0] exp);
    m.rd(a, v);
    check(v, exp);
    check({15'h0000, rvalid}, 16'h0001);
  endtask
  task automatic cf(input logic [1:0] exp);
    check({14'h0000, fail_close, fail_open}, {14'h0000, exp});
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_codes;
    for (int c = 0; c < 4; c++)
    begin
      category = c[1:0];
      rc(16'h0004, 16'(c));
      rc(16'h0007, (c == 2) ? 16'h2710 : 16'hFFFF);
      rc(16'h0008, (c == 2) ? 16'h0123 : 16'hFFFF);
    end
    $display("codes done");
  endtask
  task automatic t_ident;
    abs_position = 16'h1234;
    rc(16'h0006, 16'h1234);
    rc(16'h0009, 16'h0BB8);
    rc(16'h0065, 16'h0347);
    rc(16'h0066, 16'h7A02);
    rc(16'h0067, 16'h0008);
    rc(16'h0068, 16'h0065);
    $display("ident done");
  endtask
  task automatic t_faults;
    category = 2'h1;
    fault_events = 8'hFF;
    step(1);
    fault_events = 8'h00;
    rc(16'h0069, 16'h0007);
    category = 2'h3;
    activity = 1'b1;
    gear_released = 1'b1;
    fault_events = 8'hFF;
    step(1);
    fault_events = 8'h00;
    rc(16'h0069, 16'h03F7);
    m.wr(16'h0003, 16'h0004);
    check(command, 16'h0004);
    step(1);
    check(command, 16'h0000);
    rc(16'h0069, 16'h0311);
    activity = 1'b0;
    gear_released = 1'b0;
    $display("faults done");
  endtask
  task automatic t_regs;
    m.wr(16'h0001, 16'h1388);
    m.wr(16'h0002, 16'h0005);
    m.wr(16'h0004, 16'hFFFF);
    m.wr(16'h0069, 16'hFFFF);
    check(setpoint, 16'h1388);
    check(override_mode, 16'h0005);
    rc(16'h0001, 16'h1388);
    rc(16'h0004, 16'h0003);
    rc(16'h0069, 16'h0011);
    $display("regs done");
  endtask
  task automatic t_watch;
    step(150);
    cf(2'b00);
    m.wr(16'h006D, 16'h0001);
    step(50);
    cf(2'b00);
    m.wr(16'h0002, 16'h0000);
    step(80);
    cf(2'b00);
    step(40);
    cf(2'b10);
    rc(16'h0069, 16'h0411);
    m.wr(16'h0001, 16'h1388);
    cf(2'b00);
    m.wr(16'h006D, 16'h0002);
    rc(16'h006D, 16'h0002);
    step(120);
    cf(2'b01);
    m.wr(16'h006D, 16'h0000);
    step(150);
    cf(2'b00);
    $display("watch done");
  endtask
  // ------------------------------
  // Run control
  // ------------------------------
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200us;
    fails++;
    $display("Error at %0t: run hung", $time);
    wrap_up();
  end
  initial
  begin
    step(10);
    rst = 1'b0;
    t_codes();
    t_ident();
    t_faults();
    t_regs();
    t_watch();
    wrap_up();
  end
endmodule // test_asr_regs
`default_nettype wire
